// >>> core/tape_seq_params.svh
`ifndef TAPE_SEQ_PARAMS_SVH
`define TAPE_SEQ_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_MOTION_CMD 8'h00
`define OFS_UNIT_CMD   8'h04
`define OFS_STATUS     8'h08
`define OFS_UNIT_REG   8'h0C

// ----------------------------------------
// command word bit positions
// ----------------------------------------
`define CMD_B7  7
`define CMD_B8  8
`define CMD_B9  9
`define CMD_B10 10
`define CMD_B11 11

// ----------------------------------------
// motion code values, bits 10..7
// ----------------------------------------
`define CODE_REWIND_UNLOAD 4'h6
`define CODE_RESET         4'h0

// ----------------------------------------
// sequencer stage positions
// ----------------------------------------
`define STG_ZERO    0
`define STG_ONE     1
`define STG_TWO     2
`define STG_THREE_A 3
`define STG_THREE_B 4
`define STG_IDLE    5'h00
`define STG_FIRST   5'h01

// ----------------------------------------
// status word field positions
// ----------------------------------------
`define ST_CHAIN  5
`define ST_ACTIVE 6
`define ST_EOP    7
`define ST_CODE   8
`define ST_REPLY  12
`define ST_REJECT 13

`endif

// >>> core/tape_seq_pkg.sv
package tape_seq_pkg;
  typedef logic [11:0] cmd_word_t;
  typedef logic [3:0]  motion_code_t;
  typedef logic [4:0]  stage_vec_t;
  typedef logic [2:0]  unit_reg_t;
endpackage

// >>> core/edge_rise.sv
`timescale 1ns/100ps
module edge_rise #(
  parameter int W = 1
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_level,
  output logic      [W-1:0] o_rise
);
  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  always_comb begin
    prev_d = i_level;
    o_rise = i_level & ~prev_q;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      prev_q <= i_level;  // track pin, no false edge on release
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule

// >>> core/unit_select.sv
`timescale 1ns/100ps
`include "tape_seq_params.svh"
module unit_select (
  input  wire logic                   i_clock,
  input  wire logic                   i_rst_n,
  input  wire logic                   i_cmd_valid,
  input  wire tape_seq_pkg::cmd_word_t i_cmd,
  input  wire logic [3:0]             i_unit_ok,
  output logic                        o_accept,
  output logic                        o_reject,
  output tape_seq_pkg::unit_reg_t     o_unit_reg,
  output logic [1:0]                  o_unit_drive
);
  tape_seq_pkg::unit_reg_t unit_q;
  tape_seq_pkg::unit_reg_t unit_d;
  logic                    bad_unit_code;
  logic                    bypass;

  always_comb begin
    bad_unit_code = i_cmd[`CMD_B9] | (i_cmd[`CMD_B10] & i_cmd[`CMD_B11]);         // [R14]
    bypass        = i_cmd_valid & i_cmd[`CMD_B10];                               // [R11]
    o_unit_drive  = bypass ? i_cmd[1:0] : unit_q[1:0];                           // [R10]
    o_accept      = i_cmd_valid & !bad_unit_code & i_unit_ok[o_unit_drive];      // [R11]
    o_reject      = i_cmd_valid & !o_accept;                                     // [R11]
    unit_d        = unit_q;
    if (o_accept) begin
      unit_d = {i_cmd[`CMD_B10], o_unit_drive};                                  // [R10]
    end
    o_unit_reg = unit_q;
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      unit_q <= 3'h0;
    end else begin
      unit_q <= unit_d;                                                          // [R12]
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_reject_keeps_unit: assert property (o_reject |=> unit_q == $past(unit_q)) // [R12]
    else $error("rejected unit select changed the stored unit");
  a_bad_code_refused: assert property (i_cmd_valid && bad_unit_code |-> o_reject) // [R14]
    else $error("illegal unit code was accepted");
endmodule

// >>> core/tape_motion_sequencer_ctl.sv
`timescale 1ns/100ps
`include "tape_seq_params.svh"
// Notes on behaviour
// [R1] end flag clears on op-done rise, and on tape-start rise during reverse
// [R2] end flag clears when transport ready rises after a rewind
// [R3] five one-hot stages visited zero, one, two, three-a, three-b; plus chain flag
// [R4] strobe starts stage zero only when idle or on leaving three-b; gap, end flag, gap advance
// [R5] three-a advances unconditionally; three-b waits for stop tick
// [R6] entering stage one drops stage zero, keeping one stage active
// [R7] strobe while controller active sets the chain flag
// [R8] without chain, leaving last stage stops and drops controller active
// [R9] with chain, last stage restarts at stage zero without stopping
// [R10] three-bit unit register; selector picks stored or new unit
// [R11] unit command checks chosen unit status, replies or rejects
// [R12] rejected unit command keeps previous unit connected; with bit 10 set, o_unit_sel shows the rejected unit for one cycle
// [R13] motion code legal when bits 7, 8, 10 all equal
// [R14] unit code illegal when bit 9, or bits 10 and 11 set
// [R15] chain condition: legal, bit 10 low, bits 7-8 match held code
// [R16] control accepted if legal, write allowed, and idle or chaining at end
// [R17] motion code loads on strobe except reverse at start or unload
// [R18] reverse at tape start replies, no motion, clears end flag
// [R19] reset clears stages, chain flag and controller active
// [R20] host strobes only after previous answer, with stable command
module tape_motion_sequencer_ctl (
  input  wire logic                    i_clock,
  input  wire logic                    i_rst_n,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    i_phase_enc_op_done,
  input  wire logic                    i_begin_tape_marker,
  input  wire logic                    i_transport_ready,
  input  wire logic                    i_rewind_op,
  input  wire logic                    i_record_done,
  input  wire logic                    i_lead_gap_done,
  input  wire logic                    i_trail_gap_done,
  input  wire logic                    i_stop_timing_tick,
  input  wire logic                    i_ring_present,
  input  wire logic                    i_transport_busy,
  input  wire logic                    i_lockout,
  input  wire logic                    i_abort,
  input  wire logic [3:0]              i_unit_ok,
  output logic                         o_reply,
  output logic                         o_reject,
  output logic                         o_controller_active,
  output logic                         o_end_of_op_flag,
  output tape_seq_pkg::stage_vec_t     o_seq_stage,
  output logic [1:0]                   o_unit_sel
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  tape_seq_pkg::stage_vec_t     stage_q, stage_d;
  tape_seq_pkg::motion_code_t   code_q, code_d;
  tape_seq_pkg::cmd_word_t      cmd;
  tape_seq_pkg::unit_reg_t      unit_reg;
  logic        chain_q, chain_d, active_q, active_d;
  logic        eop_q, eop_d, rewind_seen_q, rewind_seen_d;
  logic        reply_q, reply_d, reject_q, reject_d;
  logic        ready_q, ready_d, err_q, err_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0]  unit_sel_q, unit_sel_d;
  logic [2:0]  rise;
  logic [1:0]  unit_drive;
  logic        access, done, wr_motion, wr_unit, unit_acc, unit_rej;
  logic        motion_code_legal, chain_condition, control_fn_legal;
  logic        bot_reverse, rewind_unload_op, motion_go, load_code;
  logic        advance, stop, rev_running, eop_clear;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  always_comb begin
    access    = psel & penable;
    done      = access & ready_q;
    wr_motion = done & pwrite & (paddr == `OFS_MOTION_CMD);
    wr_unit   = done & pwrite & (paddr == `OFS_UNIT_CMD);
    cmd       = pwdata[11:0];
    ready_d   = access & !ready_q;
    rdata_d   = rdata_q;
    err_d     = 1'b0;
    if (access && !ready_q) begin
      rdata_d = 32'h0000_0000;
      unique case (paddr)
        `OFS_MOTION_CMD,
        `OFS_UNIT_CMD: begin
          err_d = !pwrite;
        end
        `OFS_STATUS: begin
          err_d = pwrite;
          rdata_d[4:0]                 = stage_q;
          rdata_d[`ST_CHAIN]           = chain_q;
          rdata_d[`ST_ACTIVE]          = active_q;
          rdata_d[`ST_EOP]             = eop_q;
          rdata_d[`ST_CODE+3:`ST_CODE] = code_q;
          rdata_d[`ST_REPLY]           = reply_q;
          rdata_d[`ST_REJECT]          = reject_q;
        end
        `OFS_UNIT_REG: begin
          err_d        = pwrite;
          rdata_d[2:0] = unit_reg;
        end
        default: begin
          err_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ready_q <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ready_q <= ready_d;
      err_q   <= err_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // edges and unit select
  // ----------------------------------------
  edge_rise #(.W(3)) u_edges (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_level ({i_transport_ready, i_begin_tape_marker, i_phase_enc_op_done}),
    .o_rise  (rise)
  );

  unit_select u_unit (
    .i_clock      (i_clock),
    .i_rst_n      (i_rst_n),
    .i_cmd_valid  (wr_unit),
    .i_cmd        (cmd),
    .i_unit_ok    (i_unit_ok),
    .o_accept     (unit_acc),
    .o_reject     (unit_rej),
    .o_unit_reg   (unit_reg),
    .o_unit_drive (unit_drive)
  );

  // ----------------------------------------
  // function decoder
  // ----------------------------------------
  always_comb begin
    motion_code_legal = (cmd[`CMD_B7] & cmd[`CMD_B8] & cmd[`CMD_B10])
                      | (!cmd[`CMD_B7] & !cmd[`CMD_B8] & !cmd[`CMD_B10]);   // [R13]
    chain_condition = motion_code_legal & !cmd[`CMD_B10]
                    & (cmd[`CMD_B7] == code_q[0])
                    & (cmd[`CMD_B8] == code_q[1]);                          // [R15]
    control_fn_legal = motion_code_legal
                     & (cmd[`CMD_B10] | cmd[`CMD_B8] | !i_ring_present)
                     & (!i_transport_busy | (chain_condition & eop_q));      // [R16]
    bot_reverse      = cmd[`CMD_B7] & cmd[`CMD_B8] & i_begin_tape_marker;   // [R18]
    rewind_unload_op = cmd[`CMD_B10:`CMD_B7] == `CODE_REWIND_UNLOAD;
    motion_go        = wr_motion & control_fn_legal & !bot_reverse;
    load_code        = motion_go & !rewind_unload_op;                       // [R17]
  end

  // ----------------------------------------
  // end-of-operation flag
  // ----------------------------------------
  always_comb begin
    rev_running   = active_q & code_q[0] & code_q[1];
    eop_clear     = rise[0]                                                  // [R1]
                  | (rise[1] & rev_running)                                  // [R1]
                  | (rise[2] & rewind_seen_q)                                // [R2]
                  | (wr_motion & control_fn_legal & bot_reverse);            // [R18]
    eop_d         = eop_q;
    if (eop_clear) begin
      eop_d = 1'b0;
    end
    if (i_record_done) begin
      eop_d = 1'b1;
    end
    rewind_seen_d = rewind_seen_q;
    if (rise[2]) begin
      rewind_seen_d = 1'b0;
    end
    if (i_rewind_op) begin
      rewind_seen_d = 1'b1;
    end
  end

  // ----------------------------------------
  // motion sequencer
  // ----------------------------------------
  always_comb begin
    advance = (stage_q[`STG_ZERO] & i_lead_gap_done)
            | (stage_q[`STG_ONE] & eop_q)
            | (stage_q[`STG_TWO] & i_trail_gap_done)
            | stage_q[`STG_THREE_A]                                          // [R5]
            | (stage_q[`STG_THREE_B] & i_stop_timing_tick);                  // [R4] [R5]
    stage_d  = stage_q;
    chain_d  = chain_q;
    active_d = active_q;
    code_d   = code_q;
    stop     = 1'b0;
    if (advance) begin
      stage_d = {stage_q[3:0], 1'b0};                                        // [R3] [R6]
    end
    if (stage_q[`STG_THREE_B]) begin
      if (chain_q) begin
        stage_d = `STG_FIRST;                                                // [R9]
        chain_d = 1'b0;
      end else if (i_stop_timing_tick) begin
        stop     = 1'b1;                                                     // [R8]
        active_d = 1'b0;
      end
    end
    if (motion_go) begin
      if (active_q && !stop) begin
        chain_d = 1'b1;                                                      // [R7]
      end
      if (stage_d == `STG_IDLE && !stage_q[`STG_TWO]) begin
        stage_d = `STG_FIRST;                                                // [R4]
      end
      active_d = 1'b1;
    end
    if (load_code) begin
      code_d = cmd[`CMD_B10:`CMD_B7];                                        // [R17]
    end
    if (stop || i_lockout || i_abort) begin
      code_d = `CODE_RESET;                                                  // [R17]
    end
  end

  // ----------------------------------------
  // answers and state registers
  // ----------------------------------------
  always_comb begin
    reply_d    = (wr_motion & control_fn_legal) | unit_acc;                  // [R11]
    reject_d   = (wr_motion & !control_fn_legal) | unit_rej;                 // [R16]
    unit_sel_d = unit_drive;                                                 // [R10]
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      stage_q       <= `STG_IDLE;                                            // [R19]
      chain_q       <= 1'b0;
      active_q      <= 1'b0;
      code_q        <= `CODE_RESET;
      eop_q         <= 1'b0;
      rewind_seen_q <= 1'b0;
      reply_q       <= 1'b0;
      reject_q      <= 1'b0;
      unit_sel_q    <= 2'h0;
    end else begin
      stage_q       <= stage_d;
      chain_q       <= chain_d;
      active_q      <= active_d;
      code_q        <= code_d;
      eop_q         <= eop_d;
      rewind_seen_q <= rewind_seen_d;
      reply_q       <= reply_d;
      reject_q      <= reject_d;
      unit_sel_q    <= unit_sel_d;
    end
  end

  always_comb begin
    prdata              = rdata_q;
    pready              = ready_q;
    pslverr             = err_q;
    o_reply             = reply_q;
    o_reject            = reject_q;
    o_controller_active = active_q;
    o_end_of_op_flag    = eop_q;
    o_seq_stage         = stage_q;
    o_unit_sel          = unit_sel_q;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_eop_opdone_clear: assert property (rise[0] && !i_record_done |=> !eop_q) // [R1]
    else $error("end flag not cleared by op done");
  a_eop_rewind_clear: assert property ( // [R2]
    rise[2] && rewind_seen_q && !i_record_done |=> !eop_q)
    else $error("end flag not cleared after rewind");
  a_stage_one_hot: assert property ($onehot0(stage_q)) // [R3]
    else $error("more than one stage active");
  a_stage_start: assert property ( // [R4]
    motion_go && stage_q == `STG_IDLE |=> stage_q == `STG_FIRST ##1 active_q)
    else $error("strobe did not start stage zero");
  a_three_a_pass: assert property ( // [R5]
    stage_q[`STG_THREE_A] |=> stage_q[`STG_THREE_B] && !stage_q[`STG_THREE_A])
    else $error("stage three-a did not advance");
  a_one_drops_zero: assert property (stage_q[`STG_ONE] |-> !stage_q[`STG_ZERO]) // [R6]
    else $error("stage zero active with stage one");
  a_chain_set: assert property (motion_go && active_q && !stop |=> chain_q) // [R7]
    else $error("chain flag not set");
  a_stop_active: assert property ( // [R8]
    stage_q[`STG_THREE_B] && !chain_q && i_stop_timing_tick && !motion_go
    |=> !active_q && stage_q == `STG_IDLE && code_q == `CODE_RESET)
    else $error("stop did not end motion");
  a_chain_restart: assert property ( // [R9]
    stage_q[`STG_THREE_B] && chain_q |=> stage_q == `STG_FIRST && active_q)
    else $error("chained restart failed");
  a_illegal_reject: assert property ( // [R13]
    wr_motion && !motion_code_legal |=> o_reject && !o_reply)
    else $error("illegal motion code not rejected");
  a_code_load: assert property ( // [R17]
    load_code && !stop && !i_lockout && !i_abort
    |=> code_q == $past(cmd[`CMD_B10:`CMD_B7]))
    else $error("motion code not loaded");
  a_bot_reverse: assert property ( // [R18]
    wr_motion && control_fn_legal && bot_reverse && !i_record_done && stage_q == `STG_IDLE
    |=> !eop_q && o_reply && stage_q == `STG_IDLE)
    else $error("reverse at tape start mishandled");

  c_chained: cover property (stage_q[`STG_THREE_B] && chain_q);
  c_stop: cover property (stop);
  c_bot_rev: cover property (wr_motion && bot_reverse);
  c_unit_rej: cover property (unit_rej);
endmodule

// >>> bench/host_apb.sv
`timescale 1ns/100ps
// ------
// host channel, apb master
// ------
module host_apb (
  input  wire logic        i_clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end

  // entered just after a rising edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    @(posedge i_clock);
    while (pready !== 1'b1) begin // command held stable until taken
      @(posedge i_clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// >>> bench/tape_motion_sequencer_ctl_test.sv
`timescale 1ns/100ps
module tape_motion_sequencer_ctl_test;
  logic        i_clock;
  logic        i_rst_n = 1'b0;
  logic [7:0]  ev = 8'h00;
  logic        ring = 1'b0;
  logic        busy = 1'b0;
  logic        abort = 1'b0;
  logic        lock = 1'b0;
  logic        act;
  logic        eopf;
  logic [3:0]  uok = 4'h0;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        o_reply;
  logic        o_reject;
  logic [1:0]  o_unit_sel;
  logic [31:0] rdat;
  logic        err;
  logic [3:0]  k;
  int          fails = 0;
  int          compares = 0;
  tape_seq_pkg::stage_vec_t o_seq_stage;

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  host_apb host_apb_inst (.i_clock(i_clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  tape_motion_sequencer_ctl tape_motion_sequencer_ctl_inst (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_phase_enc_op_done(ev[0]), .i_begin_tape_marker(ev[1]),
    .i_transport_ready(ev[2]), .i_rewind_op(ev[3]), .i_record_done(ev[4]),
    .i_lead_gap_done(ev[5]), .i_trail_gap_done(ev[6]), .i_stop_timing_tick(ev[7]),
    .i_ring_present(ring), .i_transport_busy(busy), .i_lockout(lock),
    .i_abort(abort), .i_unit_ok(uok), .o_reply(o_reply), .o_reject(o_reject),
    .o_controller_active(act), .o_end_of_op_flag(eopf), .o_seq_stage(o_seq_stage),
    .o_unit_sel(o_unit_sel));

  // ------
  // helpers
  // ------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rst();
    i_rst_n <= 1'b0;
    ev <= 8'h00;
    busy <= 1'b0;
    ring <= 1'b0;
    repeat (10) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
  endtask

  task automatic acc(input logic wr, input logic [7:0] a);
    host_apb_inst.xfer(wr, a, 32'h0000_0000, rdat, err);
    @(posedge i_clock);
  endtask

  task automatic cmd(input logic [7:0] a, input logic [11:0] c, input logic ok);
    host_apb_inst.xfer(1'b1, a, {20'h00000, c}, rdat, err);
    @(negedge i_clock);
    chk({30'h0, o_reply, o_reject}, {30'h0, ok, !ok});
    @(posedge i_clock);
  endtask

  task automatic st(input logic [31:0] mask, input logic [31:0] exp);
    acc(1'b0, 8'h08);
    chk(rdat & mask, exp);
  endtask

  task automatic stg(input tape_seq_pkg::stage_vec_t e);
    int n;
    n = 0;
    @(negedge i_clock);
    while (o_seq_stage !== e && n < 20) begin
      @(negedge i_clock);
      n++;
    end
    chk({27'h0, o_seq_stage}, {27'h0, e});
    @(posedge i_clock);
  endtask

  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge i_clock);
    ev[b] <= 1'b0;
    @(posedge i_clock);
  endtask

  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    end_of_test();
  end

  // ------
  // tests
  // ------
  initial begin
    rst();
    st(32'hFFFF_FFFF, 32'h0);
    acc(1'b0, 8'h00);
    chk({31'h0, err}, 32'h1);
    acc(1'b0, 8'h10);
    chk({31'h0, err}, 32'h1);
    acc(1'b1, 8'h08);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 16; i++) begin
      k = 4'(i);
      rst();
      cmd(8'h00, {1'b0, k, 7'h00}, k[0] == k[1] && k[1] == k[3]);
      if (k[0] == k[1] && k[1] == k[3])
        st(32'hF40, {20'h0, k, 8'h40});
    end
    abort <= 1'b1;
    @(posedge i_clock);
    abort <= 1'b0;
    st(32'hF00, 32'h0);
    rst();
    ring <= 1'b1;
    cmd(8'h00, 12'h000, 1'b0);
    cmd(8'h00, 12'h580, 1'b1);
    lock <= 1'b1;
    @(posedge i_clock);
    lock <= 1'b0;
    st(32'hF00, 32'h0);
    rst();
    cmd(8'h00, 12'h000, 1'b1);
    stg(5'h01);
    repeat (3) @(posedge i_clock);
    stg(5'h01);
    pulse(5);
    stg(5'h02);
    pulse(4);
    stg(5'h04);
    pulse(6);
    stg(5'h10);
    repeat (3) @(posedge i_clock);
    stg(5'h10);
    pulse(7);
    stg(5'h00);
    chk({31'h0, act}, 32'h0);
    st(32'hFE0, 32'h080);
    pulse(0);
    st(32'h080, 32'h0);
    chk({31'h0, eopf}, 32'h0);
    rst();
    cmd(8'h00, 12'h000, 1'b1);
    busy <= 1'b1;
    stg(5'h01);
    cmd(8'h00, 12'h000, 1'b0);
    pulse(5);
    pulse(4);
    stg(5'h04);
    cmd(8'h00, 12'h580, 1'b0);
    cmd(8'h00, 12'h000, 1'b1);
    st(32'h07F, 32'h064);
    pulse(6);
    stg(5'h01);
    chk({31'h0, act}, 32'h1);
    st(32'h060, 32'h040);
    abort <= 1'b1;
    @(posedge i_clock);
    abort <= 1'b0;
    @(posedge i_clock);
    st(32'hF00, 32'h0);
    rst();
    ev[1] <= 1'b1;
    pulse(4);
    st(32'h080, 32'h080);
    chk({31'h0, eopf}, 32'h1);
    cmd(8'h00, 12'h580, 1'b1);
    st(32'hFFF, 32'h0);
    rst();
    cmd(8'h00, 12'h580, 1'b1);
    pulse(4);
    ev[1] <= 1'b1;
    repeat (2) @(posedge i_clock);
    st(32'h080, 32'h0);
    rst();
    pulse(4);
    ev[2] <= 1'b1;
    repeat (2) @(posedge i_clock);
    st(32'h080, 32'h080);
    ev[2] <= 1'b0;
    ev[3] <= 1'b1;
    @(posedge i_clock);
    ev[3] <= 1'b0;
    @(posedge i_clock);
    ev[2] <= 1'b1;
    repeat (2) @(posedge i_clock);
    st(32'h080, 32'h0);
    rst();
    uok <= 4'b0100;
    cmd(8'h04, 12'h402, 1'b1);
    acc(1'b0, 8'h0C);
    chk(rdat, 32'h6);
    chk({30'h0, o_unit_sel}, 32'h2);
    cmd(8'h04, 12'h401, 1'b0);
    acc(1'b0, 8'h0C);
    chk(rdat, 32'h6);
    chk({30'h0, o_unit_sel}, 32'h2);
    cmd(8'h04, 12'h602, 1'b0);
    cmd(8'h04, 12'hC02, 1'b0);
    cmd(8'h04, 12'h000, 1'b1);
    acc(1'b0, 8'h0C);
    chk(rdat, 32'h2);
    end_of_test();
  end
endmodule
